/* hdl/scf_clk_if.sv */
// card clock control between engine and clock generator
`default_nettype none
interface scf_clk_if;
  logic run;
  logic level;
  logic hold;
  logic clk;
  modport ctl (output run, output level, output hold, input clk);
  modport gen (input run, input level, input hold, output clk);
endinterface : scf_clk_if
`default_nettype wire

/* hdl/scf_clkgen.sv */
// card clock generator with glitch-free restart, and glitch-free stop in hold mode
`default_nettype none
module scf_clkgen (
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  scf_clk_if.gen     cif
);
  import scf_pkg::*;

  localparam logic [7:0] HALF_M1 = 8'(CARD_CLK_HALF_CYC - 1);

  logic [7:0] cnt_q;
  logic       clk_q;
  logic       tick;
  logic       idle;

  assign tick  = (cnt_q == HALF_M1);
  // parked at the fixed level: counter held so a restart begins a full half
  assign idle  = !cif.run && (clk_q == cif.level);
  assign cif.clk = clk_q;

  always_ff @(posedge clk_i) begin
    if (reset_i || idle || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clk_q <= 1'b0;
    end else if (!cif.hold && !cif.run) begin
      // without hold mode the level follows at once and may cut a pulse
      clk_q <= cif.level;
    end else if (tick && (cif.run || clk_q != cif.level)) begin
      // finish the current half before parking: no short pulse
      clk_q <= !clk_q;
    end
  end
endmodule : scf_clkgen
`default_nettype wire

/* hdl/scf_engine.sv */
// smart card serial frame engine with apb registers
//
// The address map and register access over APB were decided locally.
`default_nettype none
module scf_engine (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        data_i,
  output var  logic        data_o,
  output var  logic        data_oe_o,
  output logic             card_clk_o,
  output logic             error_irq_o,
  output logic             rx_irq_o,
  output logic             tx_irq_o,
  output logic             tx_end_irq_o
);
  import scf_pkg::*;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // registers
  logic [3:0]    serial_mode_reg_q;
  logic [6:0]    serial_control_reg_q;
  logic [6:0]    serial_status_reg_q;
  logic [7:0]    tx_data_reg_q;
  logic [7:0]    rx_data_reg_q;
  logic [15:0]   etu_q;
  logic [1:0]    port_q;
  logic [1:0]    data_sync_q;
  // transmitter
  scf_tx_state_t tx_state_q;
  logic [15:0]   tx_cnt_q;
  logic [3:0]    tx_idx_q;
  logic [7:0]    tx_shift_reg_q;
  logic          tx_par_q;
  logic          tx_err_q;
  // receiver
  scf_rx_state_t rx_state_q;
  logic [15:0]   rx_cnt_q;
  logic [3:0]    rx_idx_q;
  logic [7:0]    rx_sh_q;

  logic wr_en, rd_en, mapped, data_s;
  logic smart, hold, odd, sync_md, xmit_on, rcv_on;
  logic rx_err_any, tx_start, tx_etu_end, rx_etu_end, rx_mid;
  logic tx_load_p, tx_err_p, tx_done_p;
  logic rx_store_p, rx_ok_p, rx_per_p, rx_fer_p, rx_ovr_p;
  logic tx_low, rx_drive_low, rx_bit_par_err;
  logic [6:0] st_set, st_clr;

  scf_clk_if cif ();

  assign data_s  = data_sync_q[1];
  assign smart   = serial_mode_reg_q[MB_SMART];
  assign hold    = serial_mode_reg_q[MB_HOLD];
  assign odd     = serial_mode_reg_q[MB_ODD];
  assign sync_md = serial_mode_reg_q[MB_SYNC];
  assign xmit_on = serial_control_reg_q[CB_XMIT];
  assign rcv_on  = serial_control_reg_q[CB_RCV];

  // apb slave: zero wait states, data latched in the setup cycle
  assign mapped = reg_hit(paddr_i, OFS_MODE) || reg_hit(paddr_i, OFS_CTRL) || reg_hit(paddr_i, OFS_STATUS) ||
                  reg_hit(paddr_i, OFS_TXDATA) || reg_hit(paddr_i, OFS_RXDATA) || reg_hit(paddr_i, OFS_ETU) ||
                  reg_hit(paddr_i, OFS_PORT);
  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign rd_en     = psel_i && !penable_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_o <= 32'h0000_0000;
      if (reg_hit(paddr_i, OFS_MODE))   prdata_o <= {28'h000_0000, serial_mode_reg_q};
      if (reg_hit(paddr_i, OFS_CTRL))   prdata_o <= {25'h000_0000, serial_control_reg_q};
      if (reg_hit(paddr_i, OFS_STATUS)) prdata_o <= {25'h000_0000, serial_status_reg_q};
      if (reg_hit(paddr_i, OFS_TXDATA)) prdata_o <= {24'h00_0000, tx_data_reg_q};
      if (reg_hit(paddr_i, OFS_RXDATA)) prdata_o <= {24'h00_0000, rx_data_reg_q};
      if (reg_hit(paddr_i, OFS_ETU))    prdata_o <= {16'h0000, etu_q};
      if (reg_hit(paddr_i, OFS_PORT))   prdata_o <= {30'h0000_0000, port_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      serial_mode_reg_q    <= 4'h0;
      serial_control_reg_q <= 7'h00;
      etu_q                <= ETU_CYC_RST;
      port_q               <= 2'h0;
      tx_data_reg_q        <= 8'h00;
    end else if (wr_en) begin
      if (reg_hit(paddr_i, OFS_MODE))   serial_mode_reg_q    <= pwdata_i[3:0];
      if (reg_hit(paddr_i, OFS_CTRL))   serial_control_reg_q <= pwdata_i[6:0];
      if (reg_hit(paddr_i, OFS_ETU))    etu_q                <= (pwdata_i[15:0] < 16'h0004) ? 16'h0004 : pwdata_i[15:0];
      if (reg_hit(paddr_i, OFS_PORT))   port_q               <= pwdata_i[1:0];
      if (reg_hit(paddr_i, OFS_TXDATA)) tx_data_reg_q        <= pwdata_i[7:0];
    end
  end

  // status flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    st_clr = 7'h00;
    if (wr_en && reg_hit(paddr_i, OFS_STATUS)) begin
      st_clr = ~pwdata_i[6:0];
    end
    if (wr_en && reg_hit(paddr_i, OFS_TXDATA)) begin
      st_clr[SB_TEMPTY] = 1'b1;
      st_clr[SB_TX_END_FLAG]   = 1'b1;
    end
    st_set              = 7'h00;
    st_set[SB_ERS]      = tx_err_p;
    st_set[SB_TX_END_FLAG]     = tx_done_p;
    st_set[SB_TEMPTY]   = smart ? tx_done_p : tx_load_p;
    st_set[SB_PER]      = rx_per_p;
    st_set[SB_FER]      = rx_fer_p;
    st_set[SB_OVERRUN_FLAG]     = rx_ovr_p;
    st_set[SB_RFULL]    = rx_ok_p;
  end

  // rcv_on does not touch the flags, so clearing it keeps them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      serial_status_reg_q <= STATUS_RST;
    end else begin
      serial_status_reg_q <= (serial_status_reg_q & ~st_clr) | st_set;
    end
  end

  // interrupt requests are levels that last while their flag stands, tx end only in normal mode while tx irq is low
  always_comb begin
    if (smart) begin
      error_irq_o  = serial_control_reg_q[CB_RIE] && (serial_status_reg_q[SB_OVERRUN_FLAG] ||
                     serial_status_reg_q[SB_PER] || serial_status_reg_q[SB_ERS]);
      tx_irq_o     = serial_control_reg_q[CB_TIE] && serial_status_reg_q[SB_TX_END_FLAG];
      tx_end_irq_o = 1'b0;
    end else begin
      error_irq_o  = serial_control_reg_q[CB_RIE] && (serial_status_reg_q[SB_OVERRUN_FLAG] ||
                     serial_status_reg_q[SB_PER] || serial_status_reg_q[SB_FER]);
      tx_irq_o     = serial_control_reg_q[CB_TIE] && serial_status_reg_q[SB_TEMPTY];
      tx_end_irq_o = serial_control_reg_q[CB_TX_END_INT_ENABLE] && serial_status_reg_q[SB_TX_END_FLAG] && !tx_irq_o;
    end
    rx_irq_o = serial_control_reg_q[CB_RIE] && serial_status_reg_q[SB_RFULL];
  end

  // line synchroniser
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_sync_q <= 2'b11;
    end else begin
      data_sync_q <= {data_sync_q[0], data_i};
    end
  end

  // transmitter
  assign rx_err_any = serial_status_reg_q[SB_OVERRUN_FLAG] || serial_status_reg_q[SB_PER] || serial_status_reg_q[SB_FER];
  assign tx_start   = !serial_status_reg_q[SB_TEMPTY] && !(sync_md && rx_err_any);
  assign tx_etu_end = (tx_cnt_q == etu_q - 16'h0001);
  assign tx_load_p  = (tx_state_q == TX_IDLE) && tx_start && xmit_on;
  assign tx_err_p   = (tx_state_q == TX_GUARD) && tx_etu_end && (tx_idx_q == IDX_ERR_WIN) && !data_s;
  // sampled at 11 etu; tx-end at 11 etu in smart hold mode, 12 etu in smart mode without hold, 10 etu in normal mode
  assign tx_done_p  = ((tx_state_q == TX_GUARD) && tx_etu_end && (hold ? (tx_idx_q == IDX_ERR_WIN && data_s) :
                      (tx_idx_q == IDX_GUARD_END && !tx_err_q))) ||
                      (!smart && (tx_state_q == TX_BITS) && tx_etu_end && (tx_idx_q == IDX_PARITY));

  always_ff @(posedge clk_i) begin
    if (reset_i || !xmit_on) begin
      tx_state_q     <= TX_IDLE;
      tx_cnt_q       <= 16'h0000;
      tx_idx_q       <= 4'h0;
      tx_shift_reg_q <= 8'h00;
      tx_par_q       <= 1'b0;
      tx_err_q       <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_cnt_q <= 16'h0000;
          tx_idx_q <= 4'h0;
          if (tx_start) begin
            tx_shift_reg_q <= tx_data_reg_q;
            tx_par_q       <= ^tx_data_reg_q ^ odd;
            tx_state_q     <= TX_BITS;
          end
        end
        TX_BITS: begin
          tx_cnt_q <= tx_etu_end ? 16'h0000 : tx_cnt_q + 16'h0001;
          if (tx_etu_end) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q != 4'h0) begin
              tx_shift_reg_q <= {1'b1, tx_shift_reg_q[7:1]};
            end
            if (tx_idx_q == IDX_PARITY) begin
              tx_state_q <= smart ? TX_GUARD : TX_IDLE;
              tx_err_q   <= 1'b0;
            end
          end
        end
        TX_GUARD: begin
          tx_cnt_q <= tx_etu_end ? 16'h0000 : tx_cnt_q + 16'h0001;
          if (tx_etu_end) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == IDX_ERR_WIN) begin
              tx_err_q <= !data_s;
            end
            if (tx_idx_q == IDX_GUARD_END) begin
              // resend from 12 etu: two etu after the parity bit ended
              if (tx_err_q) begin
                tx_shift_reg_q <= tx_data_reg_q;
                tx_par_q       <= ^tx_data_reg_q ^ odd;
                tx_idx_q       <= 4'h0;
                tx_state_q     <= TX_BITS;
              end else begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // bit on the line: start low, data lsb first, then parity or stop
  always_comb begin
    tx_low = 1'b0;
    if (tx_state_q == TX_BITS) begin
      if (tx_idx_q == 4'h0) begin
        tx_low = 1'b1;
      end else if (tx_idx_q == IDX_PARITY) begin
        tx_low = smart && !tx_par_q;
      end else begin
        tx_low = !tx_shift_reg_q[0];
      end
    end
  end

  // receiver; starts on a low level, not an edge, so a break keeps framing
  assign rx_etu_end     = (rx_cnt_q == etu_q - 16'h0001);
  assign rx_mid         = (rx_cnt_q == {1'b0, etu_q[15:1]});
  assign rx_bit_par_err = ^{rx_sh_q, data_s} ^ odd;
  assign rx_store_p     = (rx_state_q == RX_BITS) && rx_mid && (rx_idx_q == IDX_PARITY);
  assign rx_per_p       = rx_store_p && smart && rx_bit_par_err;
  assign rx_fer_p       = rx_store_p && !smart && !data_s;
  assign rx_ovr_p       = rx_store_p && !rx_per_p && !rx_fer_p && serial_status_reg_q[SB_RFULL];
  assign rx_ok_p        = rx_store_p && !rx_per_p && !rx_fer_p && !serial_status_reg_q[SB_RFULL];
  assign rx_drive_low   = (rx_state_q == RX_SIG) && (rx_idx_q == 4'h1);

  always_ff @(posedge clk_i) begin
    if (reset_i || !rcv_on) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_idx_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 16'h0000;
          rx_idx_q <= 4'h0;
          if (!data_s) begin
            rx_state_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          rx_cnt_q <= rx_etu_end ? 16'h0000 : rx_cnt_q + 16'h0001;
          if (rx_etu_end) begin
            rx_idx_q <= rx_idx_q + 4'h1;
          end
          if (rx_mid) begin
            if (rx_idx_q == 4'h0 && data_s) begin
              rx_state_q <= RX_IDLE;
            end else if (rx_idx_q == IDX_PARITY) begin
              // error signal window counted from the parity sample at 9.5 etu
              rx_state_q <= rx_per_p ? RX_SIG : RX_IDLE;
              rx_cnt_q   <= 16'h0000;
              rx_idx_q   <= 4'h0;
            end else if (rx_idx_q != 4'h0) begin
              rx_sh_q <= {data_s, rx_sh_q[7:1]};
            end
          end
        end
        RX_SIG: begin
          rx_cnt_q <= rx_etu_end ? 16'h0000 : rx_cnt_q + 16'h0001;
          if (rx_etu_end) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h1) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // overrun keeps the unread byte; a parity error still delivers it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_data_reg_q <= 8'h00;
    end else if (rx_store_p && !rx_ovr_p) begin
      rx_data_reg_q <= rx_sh_q;
    end
  end

  // open-drain line: off xmit, the port latches own the pin except while the receiver drives its error signal
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_o    <= 1'b1;
      data_oe_o <= 1'b0;
    end else if (rx_drive_low || (xmit_on && tx_low)) begin
      data_o    <= 1'b0;
      data_oe_o <= 1'b1;
    end else begin
      data_o    <= xmit_on ? 1'b1 : port_q[PB_OUT];
      data_oe_o <= xmit_on ? 1'b0 : port_q[PB_DIR];
    end
  end

  // card clock
  assign cif.run    = serial_control_reg_q[CB_CLK_EN];
  assign cif.level  = serial_control_reg_q[CB_CLK_LVL];
  assign cif.hold   = hold;
  assign card_clk_o = cif.clk;

  scf_clkgen u_clkgen (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cif     (cif)
  );
endmodule : scf_engine
`default_nettype wire

/* hdl/scf_pkg.sv */
// constants shared by the smart card frame engine
`default_nettype none
package scf_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned CARD_CLK_HALF_NS = 100;
  localparam int unsigned CARD_CLK_HALF_CYC = (CARD_CLK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [15:0] ETU_CYC_RST      = 16'h05d0;
  // frame positions, in elementary time units
  localparam logic [3:0]  IDX_PARITY       = 4'h9;
  localparam logic [3:0]  IDX_ERR_WIN      = 4'ha;
  localparam logic [3:0]  IDX_GUARD_END    = 4'hb;
  // register byte offsets
  localparam logic [7:0]  OFS_MODE         = 8'h00;
  localparam logic [7:0]  OFS_CTRL         = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;
  localparam logic [7:0]  OFS_TXDATA       = 8'h0c;
  localparam logic [7:0]  OFS_RXDATA       = 8'h10;
  localparam logic [7:0]  OFS_ETU          = 8'h14;
  localparam logic [7:0]  OFS_PORT         = 8'h18;
  // serial_mode_reg fields
  localparam int unsigned MB_SMART         = 0;
  localparam int unsigned MB_HOLD          = 1;
  localparam int unsigned MB_ODD           = 2;
  localparam int unsigned MB_SYNC          = 3;
  // serial_control_reg fields
  localparam int unsigned CB_CLK_EN        = 0;
  localparam int unsigned CB_CLK_LVL       = 1;
  localparam int unsigned CB_TX_END_INT_ENABLE          = 2;
  localparam int unsigned CB_RCV           = 3;
  localparam int unsigned CB_XMIT          = 4;
  localparam int unsigned CB_RIE           = 5;
  localparam int unsigned CB_TIE           = 6;
  // serial_status_reg fields
  localparam int unsigned SB_TX_END_FLAG          = 0;
  localparam int unsigned SB_PER           = 1;
  localparam int unsigned SB_FER           = 2;
  localparam int unsigned SB_OVERRUN_FLAG          = 3;
  localparam int unsigned SB_RFULL         = 4;
  localparam int unsigned SB_TEMPTY        = 5;
  localparam int unsigned SB_ERS           = 6;
  localparam logic [6:0]  STATUS_RST       = 7'h21;
  // port latch fields
  localparam int unsigned PB_OUT           = 0;
  localparam int unsigned PB_DIR           = 1;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_BITS  = 3'b010,
    TX_GUARD = 3'b100
  } scf_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_BITS = 3'b010,
    RX_SIG  = 3'b100
  } scf_rx_state_t;
endpackage : scf_pkg
`default_nettype wire

/* verification/scf_card_model.sv */
// ic card model on the shared, pulled-up data line
`default_nettype none
module scf_card_model #(
  parameter int ETU = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic pull_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc_n      = 0;
  int last_start = 0;
  initial pull_low_o = 1'b0;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  task automatic pass(input int n);
    repeat (n) @(posedge clk_i);
  endtask : pass
  // takes one device frame; nack answers with a low error signal
  task automatic take_frame(input logic nack, output logic [7:0] b, output logic pok, output int gap);
    logic [9:0] sh;
    for (int t = 0; t < 9000 && line_i !== 1'b0; t++) @(posedge clk_i);
    gap = cyc_n - last_start - 10 * ETU;
    last_start = cyc_n;
    pass(ETU / 2);
    for (int i = 0; i < 10; i++) begin
      sh[i] = line_i;
      pass(ETU);
    end
    b = sh[8:1];
    pok = ~^sh[9:1];
    pull_low_o <= nack;
    pass(ETU);
    pull_low_o <= 1'b0;
    #1;
  endtask : take_frame
  // sends one frame to the device; bad flips the parity bit
  task automatic give_frame(input logic [7:0] b, input logic bad, output logic err);
    logic [9:0] fr;
    fr = {^b ^ bad, b, 1'b0};
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      pull_low_o <= !fr[i];
      pass(ETU);
    end
    pull_low_o <= 1'b0;
    pass(ETU);
    err = !line_i;
    pass(ETU + ETU / 2);
    #1;
  endtask : give_frame
endmodule : scf_card_model
`default_nettype wire

/* verification/scf_engine_asserts.sv */
// port-level assertions for the smart card frame engine
`default_nettype none
module scf_engine_asserts (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        data_i,
  input wire logic        data_o,
  input wire logic        data_oe_o,
  input wire logic        card_clk_o,
  input wire logic        error_irq_o,
  input wire logic        rx_irq_o,
  input wire logic        tx_irq_o,
  input wire logic        tx_end_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import scf_pkg::*;
  // shadows rebuilt from bus writes; status is not mirrored, hardware sets it
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [1:0] port_q;
  wire logic  wr_en  = psel_i & penable_i & pwrite_i;
  wire logic  mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFS_PORT);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      port_q <= 2'h0;
    end else if (wr_en) begin
      mode_q <= (paddr_i == OFS_MODE) ? pwdata_i[7:0] : mode_q;
      ctrl_q <= (paddr_i == OFS_CTRL) ? pwdata_i[7:0] : ctrl_q;
      port_q <= (paddr_i == OFS_PORT) ? pwdata_i[1:0] : port_q;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  AST_READY: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
  AST_SLVERR: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
    else $error("slave error does not follow the address map");
  AST_SMART_NO_TEI: assert property (mode_q[MB_SMART] |-> !tx_end_irq_o)
    else $error("tx end irq raised in smart mode");
  AST_TX_FIRST: assert property (tx_irq_o |-> !tx_end_irq_o)
    else $error("tx end irq beside tx irq");
  AST_RIE_GATE: assert property (!ctrl_q[CB_RIE] |-> !error_irq_o && !rx_irq_o)
    else $error("rx side irq without its enable");
  AST_TIE_GATE: assert property (!ctrl_q[CB_TIE] |-> !tx_irq_o)
    else $error("tx irq without its enable");
  AST_TX_END_INT_ENABLE_GATE: assert property (!ctrl_q[CB_TX_END_INT_ENABLE] |-> !tx_end_irq_o)
    else $error("tx end irq without its enable");
  AST_CLK_MIN: assert property ($changed(card_clk_o) |=> $stable(card_clk_o))
    else $error("card clock pulse shorter than two cycles");
  AST_CLK_PARK: assert property ((!ctrl_q[CB_CLK_EN] && $stable(ctrl_q)) [*6] |-> card_clk_o == ctrl_q[CB_CLK_LVL])
    else $error("stopped card clock not at selected level");
  AST_PORT_PIN: assert property ((!ctrl_q[CB_XMIT] && !ctrl_q[CB_RCV] && $stable(port_q)) [*3]
    |-> data_oe_o == port_q[PB_DIR] && (!port_q[PB_DIR] || data_o == port_q[PB_OUT]))
    else $error("idle pin not following port latches");
  cover property ($rose(error_irq_o));
  cover property ($rose(rx_irq_o));
  cover property ($rose(tx_irq_o));
endmodule : scf_engine_asserts
bind scf_engine scf_engine_asserts i_asserts (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .card_clk_o(card_clk_o),
  .error_irq_o(error_irq_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .tx_end_irq_o(tx_end_irq_o)
);
`default_nettype wire

/* verification/scf_engine_tb.sv */
// self-checking bench for the smart card frame engine
`default_nettype none
module scf_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scf_pkg::*;
  localparam int ETU = 16;
  logic        clk_i     = 1'b0;
  logic        reset_i   = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  wire  logic [31:0] prdata_o;
  wire  logic  pready_o, pslverr_o, data_o, data_oe_o, card_clk_o, card_low;
  wire  logic  error_irq_o, rx_irq_o, tx_irq_o, tx_end_irq_o;
  wire  logic  line = !((data_oe_o && !data_o) || card_low);
  int          err_total = 0;
  int          n_checks  = 0;
  always #25 clk_i = ~clk_i;
  scf_engine i_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .data_i(line), .data_o(data_o), .data_oe_o(data_oe_o), .card_clk_o(card_clk_o),
    .error_irq_o(error_irq_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .tx_end_irq_o(tx_end_irq_o));
  scf_card_model #(.ETU(ETU)) i_card (.clk_i(clk_i), .line_i(line), .pull_low_o(card_low));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic se);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        s;
    apb(1'b1, a, d, r, s);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic s);
    apb(1'b0, a, 32'h0, d, s);
  endtask : rd
  initial begin
    logic [31:0] d;
    logic [7:0]  b;
    logic        s, pok, err, c;
    int          gap, tg;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(OFS_STATUS, d, s);
    check("status after reset", d, 32'h21);
    rd(8'h1c, d, s);
    check("unmapped data", d, 32'h0);
    check("unmapped error", s, 1'b1);
    wr(OFS_ETU, ETU);
    wr(OFS_CTRL, 32'h04);
    check("tx end irq", tx_end_irq_o, 1'b1);
    wr(OFS_CTRL, 32'h44);
    check("tx irq", tx_irq_o, 1'b1);
    check("tx end irq yields", tx_end_irq_o, 1'b0);
    // abort a normal frame mid-way, break then mark from the port latches
    wr(OFS_PORT, 32'h2);
    wr(OFS_TXDATA, 32'hff);
    wr(OFS_CTRL, 32'h10);
    cyc(3 * ETU);
    wr(OFS_CTRL, 32'h0);
    cyc(3);
    check("break on pin", {data_oe_o, data_o}, 2'b10);
    wr(OFS_PORT, 32'h3);
    cyc(3);
    check("mark on pin", {data_oe_o, data_o}, 2'b11);
    wr(OFS_PORT, 32'h0);
    // smart transmit, clock hold off: tx end comes late
    wr(OFS_MODE, 32'h1);
    fork
      i_card.take_frame(1'b0, b, pok, gap);
      begin
        wr(OFS_TXDATA, 32'ha5);
        wr(OFS_CTRL, 32'h70);
      end
    join
    check("card byte", b, 8'ha5);
    check("card parity", pok, 1'b1);
    check("tx end not yet", tx_irq_o, 1'b0);
    for (int t = 0; t < 4 * ETU && tx_irq_o !== 1'b1; t++) cyc(1);
    check("tx irq on tx end", tx_irq_o, 1'b1);
    check("no tx end irq", tx_end_irq_o, 1'b0);
    rd(OFS_STATUS, d, s);
    check("empty with end", d, 32'h21);
    // smart transmit with hold mode, first frame refused by the card
    wr(OFS_MODE, 32'h3);
    fork
      begin
        i_card.take_frame(1'b1, b, pok, gap);
        check("no tx end on error", tx_irq_o, 1'b0);
        check("error irq", error_irq_o, 1'b1);
        i_card.take_frame(1'b0, b, pok, gap);
      end
      wr(OFS_TXDATA, 32'h3c);
    join
    check("resent byte", b, 8'h3c);
    check("resend gap", 32'(gap >= 2 * ETU), 32'h1);
    check("early tx end", tx_irq_o, 1'b1);
    rd(OFS_STATUS, d, s);
    check("error signal flag", d, 32'h61);
    wr(OFS_STATUS, 32'h3f);
    rd(OFS_STATUS, d, s);
    check("flag cleared alone", d, 32'h21);
    // smart receive, good frame then bad parity
    wr(OFS_CTRL, 32'h28);
    i_card.give_frame(8'h5a, 1'b0, err);
    check("no error signal", err, 1'b0);
    check("rx irq", rx_irq_o, 1'b1);
    rd(OFS_RXDATA, d, s);
    check("rx byte", d, 32'h5a);
    rd(OFS_STATUS, d, s);
    check("status good rx", d, 32'h31);
    wr(OFS_STATUS, 32'h6f);
    i_card.give_frame(8'hc3, 1'b1, err);
    check("error signal", err, 1'b1);
    check("rx irq held off", rx_irq_o, 1'b0);
    cyc(40);
    check("error irq held", error_irq_o, 1'b1);
    rd(OFS_RXDATA, d, s);
    check("bad byte kept", d, 32'hc3);
    rd(OFS_STATUS, d, s);
    check("status bad rx", d, 32'h23);
    wr(OFS_STATUS, 32'h7d);
    check("error irq gone", error_irq_o, 1'b0);
    // break from the port latches in sync mode: framing error returns, tx held off
    wr(OFS_MODE, 32'h8);
    wr(OFS_PORT, 32'h2);
    wr(OFS_CTRL, 32'h28);
    cyc(12 * ETU);
    wr(OFS_STATUS, 32'h7b);
    cyc(12 * ETU);
    rd(OFS_STATUS, d, s);
    check("break frames again", d[SB_FER], 1'b1);
    check("error irq on break", error_irq_o, 1'b1);
    wr(OFS_TXDATA, 32'h55);
    wr(OFS_CTRL, 32'h10);
    cyc(4 * ETU);
    rd(OFS_STATUS, d, s);
    check("no tx while rx error", d[SB_TEMPTY], 1'b0);
    check("rx off keeps flags", d[SB_FER], 1'b1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PORT, 32'h0);
    wr(OFS_STATUS, 32'h7b);
    wr(OFS_MODE, 32'h3);
    // card clock: level first, then run, then stop at level
    wr(OFS_CTRL, 32'h02);
    cyc(8);
    check("clock parked", card_clk_o, 1'b1);
    wr(OFS_CTRL, 32'h03);
    tg = 0;
    for (int i = 0; i < 40; i++) begin
      c = card_clk_o;
      cyc(1);
      tg += int'(card_clk_o !== c);
    end
    check("clock toggles", 32'(tg == 19 || tg == 20), 32'h1);
    wr(OFS_CTRL, 32'h02);
    cyc(8);
    check("clock stopped", card_clk_o, 1'b1);
    complete_run();
  end
  initial begin
    #(30000 * 50);
    err_total++;
    complete_run();
  end
endmodule : scf_engine_tb
`default_nettype wire
